// ### rtl/port_oe_pkg.sv
// Purpose: constants for the port C/D/E output-enable block
// Assumes: byte-wide register port, 16-bit address
// Notes: offsets are byte addresses on the register port
package port_oe_pkg;
  // ************************************
  // address map
  // ************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] PORT_C_OE_ADDR = 16'h30b2;
  localparam logic [15:0] PORT_D_OE_ADDR = 16'h30b3;
  localparam logic [15:0] PORT_E_OE_ADDR = 16'h30b4;
  // ************************************
  // fields and reset values
  // ************************************
  localparam int PC_PINS = 8;
  localparam int PD_PINS = 8;
  localparam int PE_PINS = 5;
  localparam logic [7:0] PORT_C_OE_RESET = 8'h00;
  localparam logic [7:0] PORT_D_OE_RESET = 8'h00;
  localparam logic [4:0] PORT_E_OE_RESET = 5'h00;
  localparam logic [2:0] PORT_E_RSVD_VALUE = 3'h0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage

// ### rtl/oe_reg.sv
// Purpose: one output-enable register of configurable width
// Assumes: write strobe is already decoded for this register
// Notes: bits above WIDTH are not stored
`timescale 1ns/1ps
module oe_reg
  import port_oe_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write side
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  // register value
  output logic [WIDTH-1:0] value
);
  typedef struct packed {
    logic [WIDTH-1:0] bits;
  } oe_state_t;

  oe_state_t state_q;
  oe_state_t state_d;

  // ************************************
  // next state
  // ************************************
  always_comb begin
    state_d = state_q;
    if (wr_en) begin
      state_d.bits = wr_data;
    end
  end

  // ************************************
  // storage
  // ************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '{bits: RESET_VAL};
    end else begin
      state_q <= state_d;
    end
  end

  assign value = state_q.bits;
endmodule

// ### rtl/port_output_enable_cde.sv
// Purpose: output-enable registers for ports C, D and E
// Assumes: single-cycle strobes, read data valid the cycle after the read strobe
// Notes: unmapped reads return zero, unmapped writes are ignored
// Behaviour
// RULE_01: each port C pin drives when its enable bit is 1, not when 0.
// RULE_02: port C enable register sits at 30B2h and resets to zero.
// RULE_03: each port D pin drives when its enable bit is 1, not when 0.
// RULE_04: port D enable register sits at 30B3h and resets to zero.
// RULE_05: port E pins 0..4 drive when enable bits 4..0 are 1; the code drives each pin n from enable bit n.
// RULE_06: port E bits 7..5 read zero and ignore writes.
// RULE_07: port E enable register decoded as one byte at 30B4h.
// RULE_08: port E enable bits reset to zero.
`timescale 1ns/1ps
module port_output_enable_cde
  import port_oe_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [DATA_W-1:0] RDATA,
  // pad driver enables
  output logic [PC_PINS-1:0] PC_DRIVE_EN,
  output logic [PD_PINS-1:0] PD_DRIVE_EN,
  output logic [PE_PINS-1:0] PE_DRIVE_EN
);
  typedef struct packed {
    logic [DATA_W-1:0] rdata;
  } rd_state_t;

  // ************************************
  // signals
  // ************************************
  // read data register
  rd_state_t state_q;
  rd_state_t state_d;
  // stored enable bits
  logic [PC_PINS-1:0] pc_oe;
  logic [PD_PINS-1:0] pd_oe;
  logic [PE_PINS-1:0] pe_oe;
  // address hits
  logic sel_c;
  logic sel_d;
  logic sel_e;
  // qualified write strobes
  logic wr_c;
  logic wr_d;
  logic wr_e;
  // write data per register
  logic [PC_PINS-1:0] wdata_c;
  logic [PD_PINS-1:0] wdata_d;
  logic [PE_PINS-1:0] wdata_e;
  // read-back words
  logic [DATA_W-1:0] rword_c;
  logic [DATA_W-1:0] rword_d;
  logic [DATA_W-1:0] rword_e;

  // ************************************
  // address decode
  // ************************************
  assign sel_c = (ADDR == PORT_C_OE_ADDR); // RULE_02
  assign sel_d = (ADDR == PORT_D_OE_ADDR); // RULE_04
  assign sel_e = (ADDR == PORT_E_OE_ADDR); // RULE_07

  // ************************************
  // write strobes
  // ************************************
  // unmapped writes hit no register
  assign wr_c = WR && sel_c;
  assign wr_d = WR && sel_d;
  assign wr_e = WR && sel_e;

  // ************************************
  // write data
  // ************************************
  assign wdata_c = WDATA[PC_PINS-1:0];
  assign wdata_d = WDATA[PD_PINS-1:0];
  // upper three data bits are dropped here
  assign wdata_e = WDATA[PE_PINS-1:0]; // RULE_06

  // ************************************
  // registers
  // ************************************
  oe_reg #(
    .WIDTH(PC_PINS),
    .RESET_VAL(PORT_C_OE_RESET)
  ) u_port_c_output_enable ( // RULE_02
    .clk(MCLK),
    .rst_n(RST_N),
    .wr_en(wr_c),
    .wr_data(wdata_c),
    .value(pc_oe)
  );

  oe_reg #(
    .WIDTH(PD_PINS),
    .RESET_VAL(PORT_D_OE_RESET)
  ) u_port_d_output_enable ( // RULE_04
    .clk(MCLK),
    .rst_n(RST_N),
    .wr_en(wr_d),
    .wr_data(wdata_d),
    .value(pd_oe)
  );

  oe_reg #(
    .WIDTH(PE_PINS),
    .RESET_VAL(PORT_E_OE_RESET)
  ) u_port_e_output_enable ( // RULE_08
    .clk(MCLK),
    .rst_n(RST_N),
    .wr_en(wr_e),
    .wr_data(wdata_e),
    .value(pe_oe)
  );

  // ************************************
  // read-back words
  // ************************************
  assign rword_c = pc_oe;
  assign rword_d = pd_oe;
  // reserved bits read back as zero
  assign rword_e = {PORT_E_RSVD_VALUE, pe_oe}; // RULE_06

  // ************************************
  // read path
  // ************************************
  // read data stands one cycle, zero otherwise
  always_comb begin
    state_d = state_q;
    state_d.rdata = UNMAPPED_READ;
    if (RD) begin
      case (ADDR)
        PORT_C_OE_ADDR: begin
          state_d.rdata = rword_c;
        end
        PORT_D_OE_ADDR: begin
          state_d.rdata = rword_d;
        end
        PORT_E_OE_ADDR: begin // RULE_07
          state_d.rdata = rword_e;
        end
        default: begin
          state_d.rdata = UNMAPPED_READ;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= '{rdata: UNMAPPED_READ};
    end else begin
      state_q <= state_d;
    end
  end

  assign RDATA = state_q.rdata;

  // ************************************
  // pad enables
  // ************************************
  // one driver enable per pin, high drives the pin
  for (genvar n = 0; n < PC_PINS; n++) begin : g_pc_pin
    assign PC_DRIVE_EN[n] = pc_oe[n]; // RULE_01
  end

  for (genvar n = 0; n < PD_PINS; n++) begin : g_pd_pin
    assign PD_DRIVE_EN[n] = pd_oe[n]; // RULE_03
  end

  for (genvar n = 0; n < PE_PINS; n++) begin : g_pe_pin
    assign PE_DRIVE_EN[n] = pe_oe[n]; // RULE_05
  end
endmodule

// ### tb/oe_chk_assertions.sv
// Purpose: port C/D/E enable checks
// Assumes: one clock, async low reset
// Notes: bound to the top module
`timescale 1ns/1ps
module oe_chk (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // register port
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic [7:0] RDATA,
  // pad enables
  input wire logic [7:0] PC_DRIVE_EN,
  input wire logic [7:0] PD_DRIVE_EN,
  input wire logic [4:0] PE_DRIVE_EN
);
  // ********
  // properties
  // ********
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence s_w(a); WR && ADDR == a; endsequence
  sequence s_r(a); RD && ADDR == a; endsequence
  property p_cw; s_w(16'h30b2) |=> PC_DRIVE_EN == $past(WDATA); endproperty
  a_cw: assert property (p_cw) else $error("c write");
  property p_cr; s_r(16'h30b2) |=> RDATA == PC_DRIVE_EN; endproperty
  a_cr: assert property (p_cr) else $error("c read");
  property p_dw; s_w(16'h30b3) |=> PD_DRIVE_EN == $past(WDATA); endproperty
  a_dw: assert property (p_dw) else $error("d write");
  property p_dr; s_r(16'h30b3) |=> RDATA == PD_DRIVE_EN; endproperty
  a_dr: assert property (p_dr) else $error("d read");
  property p_ew; s_w(16'h30b4) |=> PE_DRIVE_EN == $past(WDATA[4:0]); endproperty
  a_ew: assert property (p_ew) else $error("e write");
  property p_er; s_r(16'h30b4) |=> RDATA == {3'h0, PE_DRIVE_EN}; endproperty
  a_er: assert property (p_er) else $error("e read");
  property p_eh; !(WR && ADDR == 16'h30b4) |=> $stable(PE_DRIVE_EN); endproperty
  a_eh: assert property (p_eh) else $error("e changed");
  property p_rs; $rose(RST_N) |-> PE_DRIVE_EN == 5'h00; endproperty
  a_rs: assert property (p_rs) else $error("e reset");
  property p_rc; $rose(RST_N) |-> PC_DRIVE_EN == 8'h00; endproperty
  a_rc: assert property (p_rc) else $error("c reset");
  property p_rd; $rose(RST_N) |-> PD_DRIVE_EN == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("d reset");
endmodule
bind port_output_enable_cde oe_chk u_chk (.MCLK(MCLK), .RST_N(RST_N), .WR(WR), .RD(RD), .ADDR(ADDR),
  .WDATA(WDATA), .RDATA(RDATA), .PC_DRIVE_EN(PC_DRIVE_EN), .PD_DRIVE_EN(PD_DRIVE_EN), .PE_DRIVE_EN(PE_DRIVE_EN));

// ### tb/port_output_enable_cde_tb.sv
// Purpose: random register traffic against a model
// Assumes: one idle cycle after each strobe
// Notes: enables and read data compared
`timescale 1ns/1ps
module port_output_enable_cde_tb;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0;
  logic [15:0] addr = 0;
  logic [7:0] wd = 0, rdat, pc, pd;
  logic [4:0] pe;
  logic [7:0] m[3];
  int error_cnt, n_tests;
  always #12.5 clk = ~clk;
  port_output_enable_cde dut (.MCLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wd), .WR(wr), .RD(rd),
    .RDATA(rdat), .PC_DRIVE_EN(pc), .PD_DRIVE_EN(pd), .PE_DRIVE_EN(pe));
  // ********
  // tasks
  // ********
  task chk(logic [20:0] s, logic [20:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %0t seen %h want %h", $time, s, e);
    end
  endtask
  task summarize;
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task op(bit w, logic [15:0] a, logic [7:0] d);
    int i;
    i = a - 16'h30b2;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 0;
    rd <= 0;
    #1;
    if (w && i inside {[0:2]}) m[i] = d & (i == 2 ? 8'h1f : 8'hff);
    if (w) chk({pc, pd, pe}, {m[0], m[1], m[2][4:0]});
    else chk(rdat, i inside {[0:2]} ? m[i] : 8'h00);
  endtask
  initial begin
    m = '{8'h00, 8'h00, 8'h00};
    void'($urandom(32'h2646));
    repeat (12) @(posedge clk);
    rst_n <= 1;
    for (int k = 0; k < 3; k++) op(0, 16'h30b2 + k, 8'h00);
    repeat (80) op($urandom % 2, 16'h30b1 + $urandom % 5, $urandom);
    op(1, 16'h30b4, 8'hff);
    op(0, 16'h30b4, 8'h00);
    @(posedge clk);
    rst_n <= 0;
    @(posedge clk);
    rst_n <= 1;
    m = '{8'h00, 8'h00, 8'h00};
    #1 chk({pc, pd, pe}, 21'h0);
    for (int k = 0; k < 3; k++) op(0, 16'h30b2 + k, 8'h00);
    op(1, 16'h30b3, 8'h3c);
    op(0, 16'h30b3, 8'h00);
    summarize;
  end
  initial begin
    #50us;
    error_cnt++;
    summarize;
  end
endmodule
